// *** include/rpst_map.svh ***
`ifndef RPST_MAP_SVH
`define RPST_MAP_SVH

// ==========================================================================
// Timing figures in input clock periods, and derived cycle counts
// ==========================================================================
// Input clock period in picoseconds (40 MHz)
`define RPST_CLK_PS           25000
// Idle inputs before reset release, least
`define RPST_T_ACT_TCK        8
// Control word to control word spacing, least
`define RPST_T_MRD_TCK        8
// Input buffer disable after both clock enables low
`define RPST_T_INDIS_MIN_TCK  1
`define RPST_T_INDIS_MAX_TCK  4
// Output hi-z after clock enable outputs low, in tenths of a period
`define RPST_T_QDIS_TENTHS    15
// Both clock enables low before the clock may stop
`define RPST_T_CKOFF_TCK      5
// Clock enable buffers kept on after the clock stops, least
`define RPST_T_CKEV_TCK       2
// Static outputs after power-save exit
`define RPST_T_FIXOUT_MIN_TCK 1
`define RPST_T_FIXOUT_MAX_TCK 3
// Derived counts: block runs on the input clock, so one period is one cycle
`define RPST_QDIS_CYC         ((`RPST_T_QDIS_TENTHS + 9) / 10)
`define RPST_CKEV_CYC         (`RPST_T_CKEV_TCK)
// Reset values
`define RPST_RST_BUF_EN       1'b1
`define RPST_RST_CKE_OUT      2'h0
`define RPST_RST_OE           1'b0

`endif

// *** include/rpst_pkg.sv ***
package rpst_pkg;
  // Power-save sequencer states, one-hot
  typedef enum logic [2:0] {
    RPST_ACTIVE = 3'b001,
    RPST_SAVE   = 3'b010,
    RPST_HALTED = 3'b100
  } rpst_state_e;

  typedef logic [1:0] rpst_cke_t;
endpackage

// *** rtl/rpst_power_seq.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rpst_map.svh"

// Contract
// RULE1 - Host idles inputs eight cycles before reset
// RULE2 - Host spaces control word accesses eight cycles
// RULE3 - Power-save entry disables inputs within 1-4
// RULE4 - Outputs go hi-z after clock enables drop
// RULE5 - Host holds enables low five cycles first
// RULE6 - Enable input buffers stay on two cycles
// RULE7 - Static outputs 1-3 cycles after exit
// RULE8 - Exit re-enables inputs, then redrive resumes
module rpst_power_seq #(
  parameter int CA_W = 22,
  parameter int CS_W = 4
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire rpst_pkg::rpst_cke_t   host_clk_en_in,
  input  wire logic [CS_W-1:0]       chip_select_in_n,
  input  wire logic [CA_W-1:0]       cmdAddrIn,
  input  wire logic [1:0]            termination_ctl_in,
  input  wire logic                  inClkStopped,
  input  wire logic                  power_save_enable_field,
  output logic                       dataInBufEn,
  output logic                       cleInBufEn,
  output rpst_pkg::rpst_cke_t        clk_en_out,
  output logic [1:0]                 termination_ctl_out,
  output logic [CS_W-1:0]            chipSelectOut,
  output logic [CA_W-1:0]            cmdAddrOut,
  output logic                       cmdAddrOe
);
  import rpst_pkg::*;

  localparam logic [2:0] QDIS_CYC = 3'(`RPST_QDIS_CYC);
  localparam logic [2:0] CKEV_CYC = 3'(`RPST_CKEV_CYC);

  // ========================================================================
  // Pin synchronisers
  // ========================================================================
  rpst_cke_t         ckeMeta, ckeSync;
  logic [CS_W-1:0]   csMeta, csSync;
  logic [CA_W-1:0]   caMeta, caSync;
  logic [1:0]        odtMeta, odtSync;
  logic              stopMeta, stopSync, pseMeta, pseSync;

  // Two flops on every pin except rst before any logic looks at it
  always_ff @(posedge ref_clk) begin
    ckeMeta  <= host_clk_en_in;
    ckeSync  <= ckeMeta;
    csMeta   <= chip_select_in_n;
    csSync   <= csMeta;
    caMeta   <= cmdAddrIn;
    caSync   <= caMeta;
    odtMeta  <= termination_ctl_in;
    odtSync  <= odtMeta;
    stopMeta <= inClkStopped;
    stopSync <= stopMeta;
    pseMeta  <= power_save_enable_field;
    pseSync  <= pseMeta;
  end

  // ========================================================================
  // Power-save sequencer
  // ========================================================================
  rpst_state_e state, next_state;
  logic        next_dataInBufEn, next_cleInBufEn, next_cmdAddrOe;
  logic        redrive, next_redrive;
  logic [2:0]  cnt, next_cnt;
  rpst_cke_t   next_clkEnOut;
  logic [1:0]  next_odtOut;
  logic [CS_W-1:0] next_csOut;
  logic [CA_W-1:0] next_caOut;
  logic        bothLow, anyHigh;

  assign bothLow = (ckeSync == 2'h0);
  assign anyHigh = (ckeSync != 2'h0);

  // Next-state and output computation
  always_comb begin
    next_state       = state;
    next_dataInBufEn = dataInBufEn;
    next_cleInBufEn  = cleInBufEn;
    next_cmdAddrOe   = cmdAddrOe;
    next_redrive     = redrive;
    next_cnt         = cnt;
    next_clkEnOut    = ckeSync;      // Enables are always passed through
    next_odtOut      = odtSync;
    next_csOut       = chipSelectOut;
    next_caOut       = cmdAddrOut;
    if (redrive) begin
      next_csOut = csSync;
      next_caOut = caSync;
    end
    unique case (state)
      RPST_ACTIVE: begin
        next_cnt = 3'h0;
        // RULE3 entry disables inputs
        if (bothLow && pseSync) begin
          next_state       = RPST_SAVE;
          next_dataInBufEn = 1'b0;
          next_redrive     = 1'b0;
        end
      end
      RPST_SAVE: begin
        // RULE4 hi-z after enables low
        // A 1.5-cycle float time rounds up to two whole cycles,
        // counted from the edge that drove the enable outputs low
        if ((cnt + 3'h1) < QDIS_CYC) begin
          next_cnt = cnt + 3'h1;
        end else begin
          next_cmdAddrOe = 1'b0;
        end
        // RULE7 static outputs on exit
        if (anyHigh) begin
          next_state       = RPST_ACTIVE;
          next_cmdAddrOe   = 1'b1;
          // RULE8 buffers back, redrive next
          next_dataInBufEn = 1'b1;
          next_redrive     = 1'b1;
        end else if (stopSync) begin
          next_state = RPST_HALTED;
          next_cnt   = 3'h0;
        end
      end
      RPST_HALTED: begin
        next_cmdAddrOe = 1'b0;
        // RULE6 enable buffers held on
        if (cnt < CKEV_CYC) begin
          next_cnt = cnt + 3'h1;
        end else begin
          next_cleInBufEn = 1'b0;
        end
        if (!stopSync) begin
          next_state      = RPST_SAVE;
          next_cleInBufEn = 1'b1;
          next_cnt        = QDIS_CYC;
        end
      end
    endcase
  end

  // Register the sequencer state and all outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state               <= RPST_ACTIVE;
      dataInBufEn         <= `RPST_RST_BUF_EN;
      cleInBufEn          <= `RPST_RST_BUF_EN;
      cmdAddrOe           <= `RPST_RST_OE;
      redrive             <= 1'b0;
      cnt                 <= 3'h0;
      clk_en_out          <= `RPST_RST_CKE_OUT;
      termination_ctl_out <= 2'h0;
      chipSelectOut       <= '1;
      cmdAddrOut          <= '0;
    end else begin
      state               <= next_state;
      dataInBufEn         <= next_dataInBufEn;
      cleInBufEn          <= next_cleInBufEn;
      cmdAddrOe           <= next_cmdAddrOe;
      redrive             <= next_redrive;
      cnt                 <= next_cnt;
      clk_en_out          <= next_clkEnOut;
      termination_ctl_out <= next_odtOut;
      chipSelectOut       <= next_csOut;
      cmdAddrOut          <= next_caOut;
    end
  end

  // ========================================================================
  // Assertions
  // ========================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Pins reach the sequencer two edges after they move

  // RULE3 entry disables inputs
  a_indis_window: assert property ( // RULE3
    (state == RPST_ACTIVE && $fell(ckeMeta != 2'h0) && pseMeta && pseSync)
      |-> ##[1:4] !dataInBufEn) else $error("Input buffers not disabled in time");

  // RULE4 hi-z after enables low
  a_qdis_delay: assert property ( // RULE4
    (state == RPST_SAVE && $fell(clk_en_out != 2'h0))
      ##1 (state == RPST_SAVE && ckeSync == 2'h0)
      |-> ##1 !cmdAddrOe) else $error("Outputs not hi-z after clock enables low");

  // RULE4 no early hi-z
  a_qdis_early: assert property ( // RULE4
    $fell(cmdAddrOe) |-> (state != RPST_ACTIVE) && $past(clk_en_out, 2) == 2'h0)
    else $error("Outputs floated before clock enables low");

  // RULE6 enable buffers held on
  a_ckev_hold: assert property ( // RULE6
    $rose(state == RPST_HALTED) |-> cleInBufEn [*3])
    else $error("Clock enable buffers dropped too early");

  // RULE7 static outputs on exit
  a_fixout_exit: assert property ( // RULE7
    (state == RPST_SAVE && $rose(ckeMeta != 2'h0))
      |-> ##[1:3] cmdAddrOe) else $error("Outputs not static after exit");

  // RULE8 buffers back, redrive next
  a_exit_redrive: assert property ( // RULE8
    $rose(state == RPST_ACTIVE) |-> dataInBufEn && redrive && $stable(cmdAddrOut))
    else $error("Exit did not restore inputs with static outputs");

  // RULE8 redrive tracks inputs
  a_redrive_data: assert property ( // RULE8
    redrive && $past(redrive) |-> cmdAddrOut == $past(caSync))
    else $error("Registered data not redriven");

  // RULE3 entry needs enable field
  a_entry_gated: assert property ( // RULE3
    $fell(dataInBufEn) |-> $past(pseSync) && $past(ckeSync) == 2'h0)
    else $error("Power save entered without enable");

  // RULE7 no exit before enables seen
  a_exit_min: assert property ( // RULE7
    $rose(cmdAddrOe) |-> $past(ckeMeta, 2) != 2'h0)
    else $error("Outputs enabled before clock enables rose");

  // RULE4 enable outputs never float
  a_cke_follow: assert property ( // RULE4
    !$past(rst) |-> clk_en_out == $past(ckeSync))
    else $error("Clock enable outputs not re-driven");

endmodule
`default_nettype wire

// *** verif/rpst_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ====================
// Host controller model
module rpst_host_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        wantSave,
  input  wire logic        wantStop,
  output logic [1:0]       hostCke,
  output logic [3:0]       csN,
  output logic [21:0]      ca,
  output logic [1:0]       odt,
  output logic             clkStopped
);
  int lowCnt = 0;
  // Idle pin levels at time zero
  initial begin
    hostCke = 2'h0;
    csN = 4'hf;
    ca = 22'h0;
    odt = 2'h0;
    clkStopped = 1'b0;
  end
  // Pins move on the falling edge; data changes every cycle
  always @(negedge ref_clk) begin
    ca <= ca + 22'h1;
    odt <= ~odt;
    if (rst) begin
      hostCke <= 2'h0;
      csN <= 4'hf;
      clkStopped <= 1'b0;
      lowCnt <= 0;
    end else begin
      hostCke <= wantSave ? 2'h0 : 2'h3;
      csN <= wantSave ? 4'hf : 4'he;
      lowCnt <= (hostCke == 2'h0) ? lowCnt + 1 : 0;
      clkStopped <= wantStop && (hostCke == 2'h0) && (lowCnt >= 5);
    end
  end
endmodule
`default_nettype wire

// *** verif/register_power_save_timing_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rpst_map.svh"
// ====================
// Power-save sequencer bench
module register_power_save_timing_tb_top;
  import rpst_pkg::*;
  logic         ref_clk, rst, wantSave, wantStop, pwrSaveEn;
  logic         stopped, dataEn, cleEn, oe;
  rpst_cke_t    hostCke, cke;
  logic [3:0]   csN, csOut;
  logic [21:0]  ca, caOut;
  logic [1:0]   odt, odtOut;
  int           failCount, compares;

  rpst_host_model i_rpst_host_model (.ref_clk(ref_clk), .rst(rst), .wantSave(wantSave),
    .wantStop(wantStop), .hostCke(hostCke), .csN(csN), .ca(ca), .odt(odt),
    .clkStopped(stopped));
  rpst_power_seq i_rpst_power_seq (.ref_clk(ref_clk), .rst(rst), .host_clk_en_in(hostCke),
    .chip_select_in_n(csN), .cmdAddrIn(ca), .termination_ctl_in(odt),
    .inClkStopped(stopped), .power_save_enable_field(pwrSaveEn), .dataInBufEn(dataEn),
    .cleInBufEn(cleEn), .clk_en_out(cke), .termination_ctl_out(odtOut),
    .chipSelectOut(csOut), .cmdAddrOut(caOut), .cmdAddrOe(oe));

  task automatic results;
    $display("compares %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      failCount++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  // Bounded wait, counted in falling edges
  task automatic waitFor(ref logic sig, input logic val, input int lim, output int c);
    c = 0;
    while (sig !== val && c < lim) begin
      @(negedge ref_clk);
      c++;
    end
    if (sig !== val) begin
      chk(1'b0, "wait timed out");
      results();
    end
  endtask
  task automatic t_exit;
    int c;
    wantSave <= 1'b0;
    waitFor(oe, 1'b1, 8, c);
    chk(c >= 3 && c <= 4, "exit latency");
    chk(dataEn === 1'b1, "inputs not back");
    repeat (2) @(negedge ref_clk);
    chk(caOut === ca - 22'h2 && csOut === 4'he, "no redrive");
  endtask
  task automatic t_entry;
    int c;
    wantSave <= 1'b1;
    waitFor(dataEn, 1'b0, 8, c);
    chk(c >= 3 && c <= 5 && cke === 2'h0, "input disable");
    waitFor(oe, 1'b0, 8, c);
    chk(c == `RPST_QDIS_CYC, "hi-z delay");
    chk(odtOut === odt && cke === 2'h0, "enables or termination floated");
    wantStop <= 1'b1;
    waitFor(stopped, 1'b1, 12, c);
    repeat (2) begin
      @(negedge ref_clk);
      chk(cleEn === 1'b1, "enable buffers early off");
    end
    waitFor(cleEn, 1'b0, 8, c);
    chk(oe === 1'b0 && dataEn === 1'b0, "outputs driven while halted");
    wantStop <= 1'b0;
    waitFor(cleEn, 1'b1, 8, c);
  endtask
  task automatic t_refuse;
    pwrSaveEn <= 1'b0;
    repeat (8) @(negedge ref_clk);
    wantSave <= 1'b1;
    repeat (8) begin
      @(negedge ref_clk);
      chk(dataEn === 1'b1 && oe === 1'b1, "saved while off");
    end
    pwrSaveEn <= 1'b1;
    repeat (`RPST_T_MRD_TCK) @(negedge ref_clk);
    chk(dataEn === 1'b0 && oe === 1'b0, "no save once enabled");
  endtask

  // Free-running input clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    wantSave = 1'b1;
    wantStop = 1'b0;
    pwrSaveEn = 1'b1;
    failCount = 0;
    compares = 0;
    repeat (`RPST_T_ACT_TCK) @(negedge ref_clk);
    chk(dataEn === 1'b1 && cleEn === 1'b1 && cke === 2'h0 && oe === 1'b0, "reset");
    rst <= 1'b0;
    @(negedge ref_clk);
    t_exit();
    t_entry();
    t_exit();
    t_refuse();
    t_exit();
    results();
  end
endmodule
`default_nettype wire
